// ===== hw/async_serial_channel_control.sv
// Purpose: One asynchronous serial channel with its line control registers
// Assumes: All inputs synchronous to clk; gear clock is clk itself
// Notes:   Summary of operation below; register port answers next cycle
//
// Chosen here: the plain strobed port.
`include "serial_chan_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module async_serial_channel_control (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_b,
   // Register port
   input  wire logic [11:0] reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   // Clock sources and system state
   input  wire logic        sys_clk_src_sel,
   input  wire logic        low_freq_clock,
   input  wire logic        external_timer_output,
   input  wire logic        low_power_entry,
   // Serial pins
   input  wire logic        serial_in_pin,
   output logic             serial_out_pin
);

   serial_chan_pkg::chan_state_t s_ff;
   serial_chan_pkg::chan_state_t nxt_s;
   logic base_tick;
   logic rt_tick;
   logic tx_lock;
   logic all_lock;
   logic rx_lock;
   logic [4:0] tx_len;
   logic [4:0] rx_len;

   // Sample clocks per bit for a code and bit position
   function automatic logic [4:0] rt_len(input logic [2:0] sel,
                                         input logic odd);
      unique case (sel)
         3'h0:    rt_len = 5'h10;
         3'h1:    rt_len = odd ? 5'h10 : 5'h11;
         3'h2:    rt_len = 5'h0F;
         3'h3:    rt_len = odd ? 5'h0F : 5'h10;
         3'h4:    rt_len = 5'h11;
         default: rt_len = 5'h10; // Reserved codes run as 16/16
      endcase
   endfunction : rt_len

   // Noise filter length in sample clocks
   function automatic logic [2:0] nf_len(input logic [1:0] sel);
      unique case (sel)
         2'h0: nf_len = 3'h0;
         2'h1: nf_len = 3'h1;
         2'h2: nf_len = 3'h2;
         2'h3: nf_len = 3'h4;
      endcase
   endfunction : nf_len

   // Base clock and sample clock; gate bit stops the sample clock and divisor
   always_comb begin
      if (s_ff.base_sel) begin
         base_tick = external_timer_output & ~s_ff.ext_q;
      end else if (sys_clk_src_sel) begin
         base_tick = low_freq_clock & ~s_ff.lf_q;
      end else begin
         base_tick = 1'b1;
      end
      // External clock bypasses the divisor but is still stopped by the gate bit
      if (s_ff.base_sel) begin
         rt_tick = base_tick & s_ff.ch_en;
      end else begin
         rt_tick = base_tick & s_ff.ch_en & (s_ff.div_cnt >= s_ff.div);
      end
      tx_lock = s_ff.tx_en | (s_ff.tx_st != serial_chan_pkg::TX_IDLE);
      rx_lock = s_ff.rx_en | (s_ff.rx_st != serial_chan_pkg::RX_IDLE);
      all_lock = tx_lock | rx_lock;
      tx_len = rt_len(s_ff.rt_sel, s_ff.tx_odd);
      rx_len = rt_len(s_ff.rt_sel, s_ff.rx_odd);
   end

   // Next state of the whole channel
   always_comb begin
      logic txv;
      logic rbit;
      txv = 1'b1;
      rbit = s_ff.filt;
      nxt_s = s_ff;
      nxt_s.ext_q = external_timer_output;
      nxt_s.lf_q = low_freq_clock;
      nxt_s.rdata = 8'h00;
      // Wrap at or above the divisor: a smaller new divisor never stalls
      if (base_tick && s_ff.ch_en) begin
         nxt_s.div_cnt = (s_ff.div_cnt >= s_ff.div) ? 8'h00
                         : s_ff.div_cnt + 8'h01;
      end

      // Register writes; protected fields keep old value when locked
      if (reg_wr) begin
         unique case (reg_addr)
            `ADR_CLK_GATE: nxt_s.ch_en = reg_wdata[`GATE_CH_EN];
            `ADR_LINE_CTL_PRI: begin
               nxt_s.tx_en = reg_wdata[`LCP_TX_EN];
               nxt_s.rx_en = reg_wdata[`LCP_RX_EN];
               if (!tx_lock) begin
                  nxt_s.tx_stop2 = reg_wdata[`LCP_TX_STOP];
                  nxt_s.ir_sel = reg_wdata[`LCP_IR_SEL];
               end
               if (!all_lock) begin
                  nxt_s.even = reg_wdata[`LCP_EVEN];
                  nxt_s.par_en = reg_wdata[`LCP_PAR_EN];
                  nxt_s.base_sel = reg_wdata[`LCP_BASE_SEL];
               end
            end
            `ADR_LINE_CTL_SEC: begin
               if (!all_lock) begin
                  nxt_s.rt_sel = reg_wdata[`LCS_RT_HI:`LCS_RT_LO];
               end
               if (!rx_lock) begin
                  nxt_s.nf_sel = reg_wdata[`LCS_NF_HI:`LCS_NF_LO];
                  nxt_s.rx_stop2 = reg_wdata[`LCS_RX_STOP];
               end
            end
            `ADR_BAUD_DIV: nxt_s.div = reg_wdata;
            `ADR_HOLDING: begin
               nxt_s.tbuf = reg_wdata;
            end
            default: ;
         endcase
      end

      // Register reads, data valid in the following cycle
      if (reg_rd) begin
         unique case (reg_addr)
            `ADR_CLK_GATE: nxt_s.rdata = {7'h00, s_ff.ch_en};
            `ADR_LINE_CTL_PRI: nxt_s.rdata = {s_ff.tx_en, s_ff.rx_en,
               s_ff.tx_stop2, s_ff.even, s_ff.par_en, s_ff.ir_sel,
               s_ff.base_sel, 1'b0};
            `ADR_LINE_CTL_SEC: nxt_s.rdata = {2'b00, s_ff.rt_sel,
               s_ff.nf_sel, s_ff.rx_stop2};
            `ADR_BAUD_DIV: nxt_s.rdata = s_ff.div;
            `ADR_CHAN_STATUS: begin
               nxt_s.rdata = {s_ff.perr, s_ff.ferr, s_ff.oerr, 1'b0,
                  s_ff.rx_st != serial_chan_pkg::RX_IDLE, s_ff.rbfl,
                  s_ff.tx_st != serial_chan_pkg::TX_IDLE, s_ff.tbfl};
               // Reading status clears errors; new errors set below
               nxt_s.perr = 1'b0;
               nxt_s.ferr = 1'b0;
               nxt_s.oerr = 1'b0;
            end
            `ADR_HOLDING: begin
               nxt_s.rdata = s_ff.rbuf;
               nxt_s.rbfl = 1'b0;
            end
            default: nxt_s.rdata = 8'h00;
         endcase
      end

      // Receive noise filter; level follows input after N quiet ticks
      if (nf_len(s_ff.nf_sel) == 3'h0) begin
         nxt_s.filt = serial_in_pin;
         nxt_s.nf_cnt = 3'h0;
      end else if (serial_in_pin == s_ff.filt) begin
         nxt_s.nf_cnt = 3'h0;
      end else if (rt_tick) begin
         if (s_ff.nf_cnt + 3'h1 >= nf_len(s_ff.nf_sel)) begin
            nxt_s.filt = serial_in_pin;
            nxt_s.nf_cnt = 3'h0;
         end else begin
            nxt_s.nf_cnt = s_ff.nf_cnt + 3'h1;
         end
      end

      // Transmitter: a started frame ends regardless of the enable
      if (rt_tick) begin
         nxt_s.tx_rt = s_ff.tx_rt + 5'h01;
         if (s_ff.tx_rt == tx_len - 5'h01) begin
            nxt_s.tx_rt = 5'h00;
            nxt_s.tx_odd = ~s_ff.tx_odd;
         end
         unique case (s_ff.tx_st)
            serial_chan_pkg::TX_IDLE: begin
               nxt_s.tx_rt = 5'h00;
               if (s_ff.tx_en && s_ff.tbfl) begin
                  nxt_s.tx_st = serial_chan_pkg::TX_START;
                  nxt_s.tx_sh = s_ff.tbuf;
                  nxt_s.tbfl = 1'b0;
                  nxt_s.tx_odd = 1'b1;
                  nxt_s.tx_bit = 3'h0;
               end
            end
            serial_chan_pkg::TX_START:
               if (nxt_s.tx_rt == 5'h00) begin
                  nxt_s.tx_st = serial_chan_pkg::TX_DATA;
               end
            serial_chan_pkg::TX_DATA:
               if (nxt_s.tx_rt == 5'h00) begin
                  nxt_s.tx_sh = {s_ff.tx_sh[0], s_ff.tx_sh[7:1]}; // Byte kept
                  nxt_s.tx_bit = s_ff.tx_bit + 3'h1;
                  if (s_ff.tx_bit == 3'h7) begin
                     nxt_s.tx_bit = 3'h0;
                     nxt_s.tx_st = s_ff.par_en ? serial_chan_pkg::TX_PAR
                                   : serial_chan_pkg::TX_STOP;
                  end
               end
            serial_chan_pkg::TX_PAR:
               if (nxt_s.tx_rt == 5'h00) begin
                  nxt_s.tx_st = serial_chan_pkg::TX_STOP;
               end
            serial_chan_pkg::TX_STOP:
               if (nxt_s.tx_rt == 5'h00) begin
                  nxt_s.tx_bit = 3'h1;
                  if (!s_ff.tx_stop2 || s_ff.tx_bit == 3'h1) begin
                     nxt_s.tx_st = serial_chan_pkg::TX_IDLE;
                     nxt_s.tx_bit = 3'h0;
                     if (!s_ff.tx_en) begin
                        nxt_s.tbfl = 1'b0;
                     end
                  end
               end
         endcase
      end

      // Parity shared with the receiver; odd when polarity is 0
      unique case (s_ff.tx_st)
         serial_chan_pkg::TX_START: txv = 1'b0;
         serial_chan_pkg::TX_DATA:  txv = s_ff.tx_sh[0];
         serial_chan_pkg::TX_PAR:   txv = ^s_ff.tx_sh ^ ~s_ff.even;
         default:                   txv = 1'b1;
      endcase
      // Infrared form: short high pulse for each zero bit, else low
      if (s_ff.ir_sel) begin
         nxt_s.txd = ~txv & (s_ff.tx_rt < `IR_PULSE_RT);
      end else begin
         nxt_s.txd = txv;
      end

      // Receiver samples each bit at its middle sample clock
      if (rt_tick) begin
         nxt_s.rx_rt = s_ff.rx_rt + 5'h01;
         if (s_ff.rx_rt == rx_len - 5'h01) begin
            nxt_s.rx_rt = 5'h00;
            nxt_s.rx_odd = ~s_ff.rx_odd;
         end
         unique case (s_ff.rx_st)
            serial_chan_pkg::RX_IDLE: begin
               nxt_s.rx_rt = 5'h00;
               nxt_s.rx_odd = 1'b1;
               nxt_s.rx_bit = 3'h0;
               nxt_s.rx_pbad = 1'b0;
               if (s_ff.rx_en && !rbit) begin
                  nxt_s.rx_st = serial_chan_pkg::RX_START;
                  nxt_s.rx_rt = 5'h01;
               end
            end
            serial_chan_pkg::RX_START:
               if (s_ff.rx_rt == {1'b0, rx_len[4:1]} && rbit) begin
                  nxt_s.rx_st = serial_chan_pkg::RX_IDLE; // False start
               end else if (nxt_s.rx_rt == 5'h00) begin
                  nxt_s.rx_st = serial_chan_pkg::RX_DATA;
               end
            serial_chan_pkg::RX_DATA: begin
               if (s_ff.rx_rt == {1'b0, rx_len[4:1]}) begin
                  nxt_s.rx_sh = {rbit, s_ff.rx_sh[7:1]};
               end
               if (nxt_s.rx_rt == 5'h00) begin
                  nxt_s.rx_bit = s_ff.rx_bit + 3'h1;
                  if (s_ff.rx_bit == 3'h7) begin
                     nxt_s.rx_bit = 3'h0;
                     nxt_s.rx_st = s_ff.par_en ? serial_chan_pkg::RX_PAR
                                   : serial_chan_pkg::RX_STOP;
                  end
               end
            end
            serial_chan_pkg::RX_PAR: begin
               if (s_ff.rx_rt == {1'b0, rx_len[4:1]}) begin
                  nxt_s.rx_pbad = rbit ^ ^s_ff.rx_sh ^ ~s_ff.even;
               end
               if (nxt_s.rx_rt == 5'h00) begin
                  nxt_s.rx_st = serial_chan_pkg::RX_STOP;
               end
            end
            serial_chan_pkg::RX_STOP:
               if (s_ff.rx_rt == {1'b0, rx_len[4:1]}) begin
                  // First of two stop bits passes unchecked
                  if (s_ff.rx_stop2 && s_ff.rx_bit == 3'h0) begin
                     nxt_s.rx_bit = 3'h1;
                  end else begin
                     nxt_s.rx_st = serial_chan_pkg::RX_IDLE;
                     nxt_s.rbuf = s_ff.rx_sh;
                     nxt_s.rbfl = 1'b1;
                     nxt_s.oerr = nxt_s.oerr | s_ff.rbfl;
                     nxt_s.ferr = nxt_s.ferr | ~rbit;
                     nxt_s.perr = nxt_s.perr | s_ff.rx_pbad;
                  end
               end
         endcase
      end

      // Holding write after the transmitter so a write beside a load is not lost
      if (reg_wr && reg_addr == `ADR_HOLDING) begin
         nxt_s.tbfl = 1'b1;
      end

      // Low-power entry stops the channel; configuration other than the enable bits is kept
      if (low_power_entry) begin
         nxt_s.tx_en = 1'b0;
         nxt_s.rx_en = 1'b0;
         nxt_s.tx_st = serial_chan_pkg::TX_IDLE;
         nxt_s.rx_st = serial_chan_pkg::RX_IDLE;
         nxt_s.tbfl = 1'b0;
         nxt_s.rbfl = 1'b0;
         nxt_s.perr = 1'b0;
         nxt_s.ferr = 1'b0;
         nxt_s.oerr = 1'b0;
         nxt_s.txd = ~s_ff.ir_sel;
      end
   end

   // State register
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         s_ff <= '0;
         s_ff.txd <= 1'b1;
         s_ff.filt <= 1'b1;
         s_ff.tx_st <= serial_chan_pkg::TX_IDLE;
         s_ff.rx_st <= serial_chan_pkg::RX_IDLE;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign reg_rdata = s_ff.rdata;
   assign serial_out_pin = s_ff.txd;

   // Checks on the control behaviour
   AST_GATE_STOPS: assert property (@(posedge clk) disable iff (!rst_b)
      !s_ff.ch_en && !low_power_entry |=> $stable(s_ff.tx_st)
      && $stable(s_ff.rx_st) && $stable(s_ff.tx_rt))
      else $error("channel moved while gated");
   AST_PRI_LOCK: assert property (@(posedge clk) disable iff (!rst_b)
      all_lock && !low_power_entry |=> $stable(s_ff.par_en)
      && $stable(s_ff.base_sel) && $stable(s_ff.even))
      else $error("protected primary field changed");
   AST_TX_LOCK: assert property (@(posedge clk) disable iff (!rst_b)
      tx_lock |=> $stable(s_ff.tx_stop2) && $stable(s_ff.ir_sel))
      else $error("transmit field changed while busy");
   AST_SEC_LOCK: assert property (@(posedge clk) disable iff (!rst_b)
      rx_lock |=> $stable(s_ff.nf_sel) && $stable(s_ff.rx_stop2))
      else $error("secondary field changed while busy");
   AST_LP_CLEAR: assert property (@(posedge clk) disable iff (!rst_b)
      low_power_entry |=> !s_ff.tx_en && !s_ff.rx_en
      && $stable(s_ff.div) && $stable(s_ff.rt_sel))
      else $error("low-power entry handling wrong");
   AST_SEC_READ: assert property (@(posedge clk) disable iff (!rst_b)
      reg_rd && reg_addr == `ADR_LINE_CTL_SEC |=> reg_rdata[7:6] == 2'b00)
      else $error("secondary upper bits not zero");
   AST_TX_FINISH: assert property (@(posedge clk) disable iff (!rst_b)
      s_ff.tx_st == serial_chan_pkg::TX_DATA && !low_power_entry
      && !s_ff.tx_en |=> s_ff.tx_st != serial_chan_pkg::TX_IDLE)
      else $error("transmit frame cut short");
   AST_TX_DROP: assert property (@(posedge clk) disable iff (!rst_b)
      s_ff.tx_st == serial_chan_pkg::TX_STOP && nxt_s.tx_st ==
      serial_chan_pkg::TX_IDLE && !s_ff.tx_en && !reg_wr |=> !s_ff.tbfl)
      else $error("held byte not discarded");
   AST_RD_NEXT: assert property (@(posedge clk) disable iff (!rst_b)
      !reg_rd |=> reg_rdata == 8'h00) else $error("read data outside slot");

endmodule : async_serial_channel_control

`default_nettype wire

// ===== hw/serial_chan_defs.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: Byte-wide register port, printed offsets used as addresses
// Notes:   Included by the channel module only; the package does not include it
`ifndef SERIAL_CHAN_DEFS_SVH
`define SERIAL_CHAN_DEFS_SVH

// Register addresses
`define ADR_LINE_CTL_PRI   12'h01A
`define ADR_LINE_CTL_SEC   12'h01B
`define ADR_BAUD_DIV       12'h01C
`define ADR_CHAN_STATUS    12'h01D
`define ADR_HOLDING        12'h01E
`define ADR_CLK_GATE       12'hF75

// Primary line control fields
`define LCP_TX_EN    7
`define LCP_RX_EN    6
`define LCP_TX_STOP  5
`define LCP_EVEN     4
`define LCP_PAR_EN   3
`define LCP_IR_SEL   2
`define LCP_BASE_SEL 1

// Secondary line control fields
`define LCS_RT_HI    5
`define LCS_RT_LO    3
`define LCS_NF_HI    2
`define LCS_NF_LO    1
`define LCS_RX_STOP  0

// Clock gate field and reset values
`define GATE_CH_EN   0
`define RST_REG8     8'h00

// Infrared pulse length in sample clocks
`define IR_PULSE_RT  5'h03
`endif

// ===== hw/serial_chan_pkg.sv
// Purpose: Types of the serial channel control block
// Assumes: serial_chan_defs.svh supplies all numeric constants
// Notes:   Whole block state is one packed struct
package serial_chan_pkg;
   typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP}
      tx_state_t;
   typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP}
      rx_state_t;

   typedef struct packed {
      logic       ch_en;
      logic       tx_en;
      logic       rx_en;
      logic       tx_stop2;
      logic       even;
      logic       par_en;
      logic       ir_sel;
      logic       base_sel;
      logic [2:0] rt_sel;
      logic [1:0] nf_sel;
      logic       rx_stop2;
      logic [7:0] div;
      logic [7:0] rdata;
      logic [7:0] tbuf;
      logic       tbfl;
      logic [7:0] rbuf;
      logic       rbfl;
      logic       perr;
      logic       ferr;
      logic       oerr;
      logic       ext_q;
      logic       lf_q;
      logic [7:0] div_cnt;
      tx_state_t  tx_st;
      logic [4:0] tx_rt;
      logic       tx_odd;
      logic [2:0] tx_bit;
      logic [7:0] tx_sh;
      logic       txd;
      rx_state_t  rx_st;
      logic [4:0] rx_rt;
      logic       rx_odd;
      logic [2:0] rx_bit;
      logic [7:0] rx_sh;
      logic       rx_pbad;
      logic       filt;
      logic [2:0] nf_cnt;
   } chan_state_t;
endpackage : serial_chan_pkg

// ===== sim/serial_peer.sv
// Purpose: Remote serial peer that receives and sends parity frames
// Assumes: Divisor 0, gear clock, sample-count code 000, 16 clk a bit
// Notes:   Parity always on, even unless bad is set
`timescale 1ns/1ps
`default_nettype none

module serial_peer (
   // Clock
   input  wire logic       clk,
   // Line
   input  wire logic       line_in,
   output logic            line_out,
   // Control and results
   input  wire logic       send,
   input  wire logic       bad,
   input  wire logic [7:0] tx_byte,
   output logic      [9:0] got,
   output int              count
);
   logic [10:0] frm;

   initial begin
      line_out = 1'b1;
      got = 10'h000;
      count = 0;
   end

   // Sample mid-bit: half a bit after the start edge, then each bit
   always begin
      @(negedge line_in);
      repeat (8) @(posedge clk);
      for (int i = 0; i < 10; i++) begin
         repeat (16) @(posedge clk);
         got[i] = line_in;
      end
      count++;
   end

   // Send start, data LSB first, parity, one stop bit
   always @(posedge clk) begin
      if (send) begin
         frm = {1'b1, (^tx_byte) ^ bad, tx_byte, 1'b0};
         for (int i = 0; i < 11; i++) begin
            line_out <= frm[i];
            repeat (16) @(posedge clk);
         end
      end
   end
endmodule : serial_peer

`default_nettype wire

// ===== sim/tb.sv
// Purpose: Self-checking bench of the serial channel control block
// Assumes: Gear clock base, divisor 0 while frames run, except the timer-base frame of t_ext
// Notes:   Each scenario is a task that judges its own results
`timescale 1ns/1ps
`default_nettype none

module tb;
   logic        clk;
   logic        rst_b;
   logic        reg_wr;
   logic        reg_rd;
   logic        low_power_entry;
   logic [11:0] reg_addr;
   logic [7:0]  reg_wdata;
   logic [7:0]  reg_rdata;
   logic [7:0]  d;
   logic [7:0]  tx_byte;
   logic        serial_in_pin;
   logic        serial_out_pin;
   logic        send;
   logic        bad;
   logic        ext_tmr;
   logic        tmr_run;
   logic [9:0]  got;
   int          count;
   int          mismatches;
   int          checked;
   int          cycles;
   int          n;
   int          c;

   // Design under test; low-frequency clock held idle, timer output driven below
   async_serial_channel_control uut (
      .clk                   (clk),
      .rst_b                 (rst_b),
      .reg_addr              (reg_addr),
      .reg_wdata             (reg_wdata),
      .reg_wr                (reg_wr),
      .reg_rd                (reg_rd),
      .reg_rdata             (reg_rdata),
      .sys_clk_src_sel       (1'b0),
      .low_freq_clock        (1'b0),
      .external_timer_output (ext_tmr),
      .low_power_entry       (low_power_entry),
      .serial_in_pin         (serial_in_pin),
      .serial_out_pin        (serial_out_pin)
   );

   // Far side of the serial pins
   serial_peer peer (
      .clk      (clk),
      .line_in  (serial_out_pin),
      .line_out (serial_in_pin),
      .send     (send),
      .bad      (bad),
      .tx_byte  (tx_byte),
      .got      (got),
      .count    (count)
   );

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // External timer output: one rising edge every two clocks while run
   always @(posedge clk) begin
      if (tmr_run) ext_tmr <= ~ext_tmr;
   end

   // Hang guard, far above the expected few thousand cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         stop_test();
      end
   end

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   // Write then idle one cycle, so the strobe is never set twice at once
   task automatic wr(input logic [11:0] a, input logic [7:0] v);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
   endtask : wr

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [11:0] a);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
      @(posedge clk);
   endtask : rd

   task automatic wait_frame();
      n = 0;
      while (count == c && n < 400) begin
         @(posedge clk);
         n++;
      end
      if (n == 400) mismatches++;
   endtask : wait_frame

   // Status reads clear errors, so the read that sees full is judged
   task automatic wait_rx();
      n = 0;
      d = 8'h00;
      while (d[2] !== 1'b1 && n < 300) begin
         rd(12'h01D);
         n++;
      end
      if (n == 300) mismatches++;
   endtask : wait_rx

   task automatic t_reset();
      rd(12'h01A); chk(d, 8'h00);
      rd(12'h01C); chk(d, 8'h00);
      rd(12'hF75); chk(d, 8'h00);
      rd(12'h010); chk(d, 8'h00);
      wr(12'h01B, 8'hFF);
      rd(12'h01B); chk(d, 8'h3F);
      wr(12'h01B, 8'h00);
   endtask : t_reset

   // Gate off holds the byte back; gate on sends it with even parity
   task automatic t_tx();
      c = count;
      wr(12'h01A, 8'h98);
      wr(12'h01E, 8'hA5);
      repeat (300) @(posedge clk);
      chk(8'(count - c), 8'h00);
      wr(12'hF75, 8'h01);
      wait_frame();
      chk(got[7:0], 8'hA5);
      chk({6'h00, got[9:8]}, {6'h00, 1'b1, ^8'hA5});
   endtask : t_tx

   task automatic t_lock();
      wr(12'h01A, 8'hA0);
      rd(12'h01A); chk(d, 8'h98);
      wr(12'h01B, 8'h3F);
      rd(12'h01B); chk(d, 8'h07);
      wr(12'h01B, 8'h00);
   endtask : t_lock

   // Disable mid-frame: frame ends whole, waiting byte is dropped
   task automatic t_drop();
      c = count;
      wr(12'h01E, 8'h11);
      repeat (40) @(posedge clk);
      wr(12'h01E, 8'h22);
      wr(12'h01A, 8'h18);
      wait_frame();
      chk(got[7:0], 8'h11);
      repeat (400) @(posedge clk);
      chk(8'(count - c), 8'h01);
      rd(12'h01D); chk(d, 8'h00);
   endtask : t_drop

   task automatic t_lp();
      wr(12'h01C, 8'h03);
      wr(12'h01B, 8'h01);
      wr(12'h01A, 8'hD8);
      low_power_entry <= 1'b1;
      @(posedge clk);
      low_power_entry <= 1'b0;
      @(posedge clk);
      rd(12'h01A); chk(d, 8'h18);
      rd(12'h01B); chk(d, 8'h01);
      rd(12'h01C); chk(d, 8'h03);
      wr(12'h01C, 8'h00);
      wr(12'h01B, 8'h00);
   endtask : t_lp

   // Shared parity setting judges received frames, good and bad
   task automatic t_rx();
      wr(12'h01A, 8'h58);
      for (int k = 0; k < 2; k++) begin
         // Peer is still sending its stop bit when the byte lands
         repeat (16) @(posedge clk);
         tx_byte <= 8'h3C;
         bad <= k[0];
         send <= 1'b1;
         @(posedge clk);
         send <= 1'b0;
         wait_rx();
         chk(d, k ? 8'h84 : 8'h04);
         rd(12'h01E); chk(d, 8'h3C);
      end
   endtask : t_rx

   // Timer base: divisor ignored, a bit is 16 timer edges of 2 clocks
   task automatic t_ext();
      wr(12'h01A, 8'h18);
      wr(12'h01A, 8'h1A);
      wr(12'h01C, 8'h05);
      wr(12'h01E, 8'h55);
      wr(12'h01A, 8'h9A);
      repeat (40) @(posedge clk);
      rd(12'h01D); chk(d, 8'h01);
      tmr_run <= 1'b1;
      n = 0;
      while (serial_out_pin !== 1'b0 && n < 100) begin
         @(negedge clk);
         n++;
      end
      c = 0;
      while (serial_out_pin === 1'b0 && c < 100) begin
         @(negedge clk);
         c++;
      end
      chk(8'(c), 8'h20);
      @(posedge clk);
      wr(12'h01A, 8'h1A);
      rd(12'h01D); chk(d, 8'h02);
      repeat (340) @(posedge clk);
      rd(12'h01D); chk(d, 8'h00);
      tmr_run <= 1'b0;
      wr(12'h01A, 8'h18);
      wr(12'h01C, 8'h00);
      rd(12'h01A); chk(d, 8'h18);
   endtask : t_ext

   task automatic t_ir();
      wr(12'h01A, 8'h18);
      wr(12'h01A, 8'h1C);
      repeat (3) @(posedge clk);
      chk({7'h00, serial_out_pin}, 8'h00);
      // A zero start bit shows as a pulse of three sample clocks
      wr(12'h01E, 8'h00);
      wr(12'h01A, 8'h9C);
      n = 0;
      while (serial_out_pin !== 1'b1 && n < 50) begin
         @(negedge clk);
         n++;
      end
      c = 0;
      while (serial_out_pin === 1'b1 && c < 50) begin
         @(negedge clk);
         c++;
      end
      chk(8'(c), 8'h03);
      @(posedge clk);
   endtask : t_ir

   task automatic stop_test();
      $display("mismatches=%0d checked=%0d", mismatches, checked);
      if (mismatches == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : stop_test

   initial begin
      rst_b = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 12'h000;
      reg_wdata = 8'h00;
      low_power_entry = 1'b0;
      send = 1'b0;
      bad = 1'b0;
      ext_tmr = 1'b0;
      tmr_run = 1'b0;
      tx_byte = 8'h00;
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      t_reset();
      t_tx();
      t_lock();
      t_drop();
      t_lp();
      t_rx();
      t_ext();
      t_ir();
      stop_test();
   end
endmodule : tb

`default_nettype wire
